// ---- hdl/sacc_pkg.sv ----
// constants, types and helpers shared by the conversion control files
package sacc_pkg;
    // register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'he8;
    localparam logic [7:0] ADDR_CONFIG = 8'hbc;
    localparam logic [7:0] ADDR_INPUT_SEL = 8'hbb;
    localparam logic [7:0] ADDR_RESULT = 8'hbf;
    localparam logic [7:0] ADDR_WIN_LOW = 8'hc4;
    localparam logic [7:0] ADDR_WIN_HIGH = 8'hc5;
    // control register bit positions
    localparam int CTL_ENABLE = 7;
    localparam int CTL_TRACK_MODE = 6;
    localparam int CTL_DONE_FLAG = 5;
    localparam int CTL_BUSY = 4;
    localparam int CTL_START_HI = 3;
    localparam int CTL_START_LO = 2;
    localparam int CTL_WIN_FLAG = 1;
    localparam int CTL_JUSTIFY = 0;
    // configuration register fields
    localparam int CFG_DIV_HI = 7;
    localparam int CFG_DIV_LO = 5;
    localparam int CFG_GAIN_HI = 2;
    localparam int CFG_GAIN_LO = 0;
    // input select register fields
    localparam int SEL_PORT_HI = 4;
    localparam int SEL_PORT_LO = 3;
    localparam int SEL_PIN_HI = 2;
    localparam int SEL_PIN_LO = 0;
    // reset values
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h01;
    localparam logic [7:0] RST_INPUT_SEL = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;
    localparam logic [7:0] RST_WIN_LOW = 8'h00;
    localparam logic [7:0] RST_WIN_HIGH = 8'hff;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // start modes
    localparam logic [1:0] START_ON_WRITE = 2'h0;
    localparam logic [1:0] START_ON_TIMER = 2'h3;
    // divider codes: 0..4 give 1,2,4,8,16; higher codes give 16
    localparam logic [2:0] DIV_MAX_CODE = 3'h4;
    localparam logic [4:0] DIV_MAX_RATIO = 5'h10;
    // sar clock counts
    localparam logic [4:0] TRACK_SAR_CLOCKS = 5'h03;
    localparam logic [4:0] CONVERT_SAR_CLOCKS = 5'h10;
    localparam logic [4:0] COUNT_ONE = 5'h01;
    localparam logic [4:0] COUNT_ZERO = 5'h00;

    typedef enum logic [1:0]
    {
        SACC_IDLE = 2'b00,
        SACC_TRACK = 2'b01,
        SACC_CONVERT = 2'b10
    } sacc_state_t;

    // result lies inside the programmed window, bounds included
    function automatic logic inWindow(input logic [7:0] value, input logic [7:0] low,
                                      input logic [7:0] high);
        inWindow = (value >= low) && (value <= high);
    endfunction : inWindow
endpackage : sacc_pkg

// ---- hdl/sacc_prescaler.sv ----
// conversion clock prescaler producing one sar tick per divide period
`timescale 1ns/1ps
`default_nettype none
module sacc_prescaler
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic [2:0] divCode,
    input wire logic restart,
    // tick out
    output logic sarTick
);
    typedef struct packed
    {
        logic [4:0] cnt;
    } sacc_presc_t;

    sacc_presc_t st;
    sacc_presc_t next_st;

    function automatic logic [4:0] ratioOf(input logic [2:0] code);
        if (code >= sacc_pkg::DIV_MAX_CODE)
        begin
            ratioOf = sacc_pkg::DIV_MAX_RATIO;
        end
        else
        begin
            ratioOf = sacc_pkg::COUNT_ONE << code;
        end
    endfunction : ratioOf

    // tick on the last count of each period; a restart begins a fresh period
    assign sarTick = !restart && (st.cnt == ratioOf(divCode) - sacc_pkg::COUNT_ONE);

    always_comb
    begin
        next_st = st;
        if (restart || sarTick)
        begin
            next_st.cnt = sacc_pkg::COUNT_ZERO;
        end
        else
        begin
            next_st.cnt = st.cnt + sacc_pkg::COUNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end
endmodule : sacc_prescaler
`default_nettype wire

// ---- hdl/sar_adc_conversion_control.sv ----
// sar converter control: registers, start, track and convert sequencing
// What this block does
// - sar clock is system clock divided by 1, 2, 4, 8 or 16 per config field.
// - start mode 00 starts on busy write, 11 on timer overflow, others reserved.
// - writing one to busy starts only in mode 00; writing zero does nothing.
// - busy reads one throughout a conversion and drops when it finishes.
// - busy falling on a finished conversion sets the complete flag and requests interrupt when enabled.
// - a finished conversion latches the result into the data register.
// - track mode zero tracks continuously while enabled, except during conversion.
// - track mode one, start mode 00: busy write starts 3 sar clocks tracking.
// - track mode one, start mode 11: timer overflow starts 3 sar clocks tracking.
// - converter, track-hold and gain stage active only while enable bit set.
// - conversion takes at least 16 sar clocks from end of tracking.
// - gain field selects 0.5 to 16 in powers of two, gain 1 after reset.
// - port and pin fields pick one external pin for the multiplexer.
// - tracking shuts down while the chip is in standby or sleep.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // special function register access
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrWr,
    input wire logic sfrRd,
    output logic [7:0] sfrRdData,
    // system events
    input wire logic timer2Overflow,
    input wire logic chipStandby,
    input wire logic eocIrqEnable,
    output logic eocIrq,
    // analog front end
    input wire logic [7:0] sarResult,
    output logic converterPowerOn,
    output logic trackEnable,
    output logic sampleConvert,
    output logic [2:0] gainSelect,
    output logic [1:0] portSelect,
    output logic [2:0] pinSelect
);
    typedef struct packed
    {
        sacc_pkg::sacc_state_t state;
        logic [4:0] cnt;
        logic [7:0] control;
        logic [7:0] adcConfiguration;
        logic [7:0] inputSel;
        logic [7:0] result;
        logic [7:0] winLow;
        logic [7:0] winHigh;
        logic [7:0] rdData;
        logic [4:0] busyCycles;
    } sacc_main_t;

    sacc_main_t st;
    sacc_main_t next_st;
    logic sarTick;
    logic busy;
    logic ctlWrite;
    logic [1:0] startMode;
    logic swStart;
    logic timerStart;
    logic startEvent;
    logic finish;

    assign busy = (st.state != sacc_pkg::SACC_IDLE);
    assign ctlWrite = sfrWr && (sfrAddr == sacc_pkg::ADDR_CONTROL);
    assign startMode = st.control[sacc_pkg::CTL_START_HI:sacc_pkg::CTL_START_LO];
    assign swStart = ctlWrite && sfrWrData[sacc_pkg::CTL_BUSY]
                     && (startMode == sacc_pkg::START_ON_WRITE);
    assign timerStart = timer2Overflow && (startMode == sacc_pkg::START_ON_TIMER);
    assign startEvent = !busy && st.control[sacc_pkg::CTL_ENABLE] && (swStart || timerStart);
    assign finish = (st.state == sacc_pkg::SACC_CONVERT) && sarTick
                    && (st.cnt == sacc_pkg::CONVERT_SAR_CLOCKS - sacc_pkg::COUNT_ONE);

    sacc_prescaler u_prescaler
    (
        .clk(clk),
        .rstn(rstn),
        .divCode(st.adcConfiguration[sacc_pkg::CFG_DIV_HI:sacc_pkg::CFG_DIV_LO]),
        .restart(startEvent),
        .sarTick(sarTick)
    );

    always_comb
    begin
        next_st = st;
        // sequencing
        unique case (st.state)
            sacc_pkg::SACC_IDLE:
            begin
                if (startEvent)
                begin
                    next_st.cnt = sacc_pkg::COUNT_ZERO;
                    if (st.control[sacc_pkg::CTL_TRACK_MODE])
                    begin
                        next_st.state = sacc_pkg::SACC_TRACK;
                    end
                    else
                    begin
                        next_st.state = sacc_pkg::SACC_CONVERT;
                    end
                end
            end
            sacc_pkg::SACC_TRACK:
            begin
                if (sarTick)
                begin
                    next_st.cnt = st.cnt + sacc_pkg::COUNT_ONE;
                    if (st.cnt == sacc_pkg::TRACK_SAR_CLOCKS - sacc_pkg::COUNT_ONE)
                    begin
                        next_st.cnt = sacc_pkg::COUNT_ZERO;
                        next_st.state = sacc_pkg::SACC_CONVERT;
                    end
                end
            end
            sacc_pkg::SACC_CONVERT:
            begin
                if (sarTick)
                begin
                    next_st.cnt = st.cnt + sacc_pkg::COUNT_ONE;
                end
                if (finish)
                begin
                    next_st.cnt = sacc_pkg::COUNT_ZERO;
                    next_st.state = sacc_pkg::SACC_IDLE;
                end
            end
            default:
            begin
                next_st.state = sacc_pkg::SACC_IDLE;
            end
        endcase
        // register writes
        if (ctlWrite)
        begin
            next_st.control[sacc_pkg::CTL_ENABLE] = sfrWrData[sacc_pkg::CTL_ENABLE];
            next_st.control[sacc_pkg::CTL_TRACK_MODE] = sfrWrData[sacc_pkg::CTL_TRACK_MODE];
            next_st.control[sacc_pkg::CTL_START_HI] = sfrWrData[sacc_pkg::CTL_START_HI];
            next_st.control[sacc_pkg::CTL_START_LO] = sfrWrData[sacc_pkg::CTL_START_LO];
            next_st.control[sacc_pkg::CTL_JUSTIFY] = sfrWrData[sacc_pkg::CTL_JUSTIFY];
            // flags clear only on a written zero
            if (!sfrWrData[sacc_pkg::CTL_DONE_FLAG])
            begin
                next_st.control[sacc_pkg::CTL_DONE_FLAG] = 1'b0;
            end
            if (!sfrWrData[sacc_pkg::CTL_WIN_FLAG])
            begin
                next_st.control[sacc_pkg::CTL_WIN_FLAG] = 1'b0;
            end
        end
        if (sfrWr)
        begin
            case (sfrAddr)
                sacc_pkg::ADDR_CONFIG: next_st.adcConfiguration = sfrWrData;
                sacc_pkg::ADDR_INPUT_SEL: next_st.inputSel = sfrWrData;
                sacc_pkg::ADDR_WIN_LOW: next_st.winLow = sfrWrData;
                sacc_pkg::ADDR_WIN_HIGH: next_st.winHigh = sfrWrData;
                default: ;
            endcase
        end
        // conversion sar clock count read only by the checks
        if (!busy)
        begin
            next_st.busyCycles = sacc_pkg::COUNT_ZERO;
        end
        else if (sampleConvert && sarTick && (st.busyCycles != '1))
        begin
            next_st.busyCycles = st.busyCycles + sacc_pkg::COUNT_ONE;
        end
        // a disabled converter drops any conversion without a result
        if (!st.control[sacc_pkg::CTL_ENABLE])
        begin
            next_st.state = sacc_pkg::SACC_IDLE;
            next_st.cnt = sacc_pkg::COUNT_ZERO;
        end
        // completion: set wins over a software clear in the same cycle
        if (finish && st.control[sacc_pkg::CTL_ENABLE])
        begin
            next_st.result = sarResult;
            next_st.control[sacc_pkg::CTL_DONE_FLAG] = 1'b1;
            if (sacc_pkg::inWindow(sarResult, st.winLow, st.winHigh))
            begin
                next_st.control[sacc_pkg::CTL_WIN_FLAG] = 1'b1;
            end
        end
        // registered read port
        if (sfrRd)
        begin
            unique case (sfrAddr)
                sacc_pkg::ADDR_CONTROL:
                begin
                    next_st.rdData = st.control;
                    next_st.rdData[sacc_pkg::CTL_BUSY] = busy;
                end
                sacc_pkg::ADDR_CONFIG: next_st.rdData = st.adcConfiguration;
                sacc_pkg::ADDR_INPUT_SEL: next_st.rdData = st.inputSel;
                sacc_pkg::ADDR_RESULT: next_st.rdData = st.result;
                sacc_pkg::ADDR_WIN_LOW: next_st.rdData = st.winLow;
                sacc_pkg::ADDR_WIN_HIGH: next_st.rdData = st.winHigh;
                default: next_st.rdData = sacc_pkg::READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st.state <= sacc_pkg::SACC_IDLE;
            st.cnt <= sacc_pkg::COUNT_ZERO;
            st.control <= sacc_pkg::RST_CONTROL;
            st.adcConfiguration <= sacc_pkg::RST_CONFIG;
            st.inputSel <= sacc_pkg::RST_INPUT_SEL;
            st.result <= sacc_pkg::RST_RESULT;
            st.winLow <= sacc_pkg::RST_WIN_LOW;
            st.winHigh <= sacc_pkg::RST_WIN_HIGH;
            st.rdData <= sacc_pkg::READ_UNMAPPED;
            st.busyCycles <= sacc_pkg::COUNT_ZERO;
        end
        else
        begin
            st <= next_st;
        end
    end

    // outputs
    assign sfrRdData = st.rdData;
    assign eocIrq = st.control[sacc_pkg::CTL_DONE_FLAG] && eocIrqEnable;
    assign converterPowerOn = st.control[sacc_pkg::CTL_ENABLE];
    assign trackEnable = st.control[sacc_pkg::CTL_ENABLE] && !chipStandby
                         && (st.control[sacc_pkg::CTL_TRACK_MODE]
                             ? (st.state == sacc_pkg::SACC_TRACK)
                             : (st.state != sacc_pkg::SACC_CONVERT));
    assign sampleConvert = (st.state == sacc_pkg::SACC_CONVERT);
    assign gainSelect = st.adcConfiguration[sacc_pkg::CFG_GAIN_HI:sacc_pkg::CFG_GAIN_LO];
    assign portSelect = st.inputSel[sacc_pkg::SEL_PORT_HI:sacc_pkg::SEL_PORT_LO];
    assign pinSelect = st.inputSel[sacc_pkg::SEL_PIN_HI:sacc_pkg::SEL_PIN_LO];

    sequence swStartSeq;
        ctlWrite && sfrWrData[sacc_pkg::CTL_BUSY] && !busy && st.control[sacc_pkg::CTL_ENABLE];
    endsequence
    sequence trackThreeSeq;
        (st.state == sacc_pkg::SACC_TRACK) [*3] ##1 (st.state == sacc_pkg::SACC_CONVERT);
    endsequence

    AST_SW_START: assert property (@(posedge clk) disable iff (!rstn)
        swStartSeq and (startMode == sacc_pkg::START_ON_WRITE) |=> busy)
        else $error("busy write in write mode did not start");
    AST_SW_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
        swStartSeq and (startMode != sacc_pkg::START_ON_WRITE) and !timerStart |=> !busy)
        else $error("busy write started outside write mode");
    AST_TIMER_START: assert property (@(posedge clk) disable iff (!rstn)
        timer2Overflow && !busy && st.control[sacc_pkg::CTL_ENABLE]
        && (startMode == sacc_pkg::START_ON_TIMER) |=> busy)
        else $error("timer overflow did not start");
    AST_DONE_ON_FALL: assert property (@(posedge clk) disable iff (!rstn)
        $fell(busy) && $past(st.control[sacc_pkg::CTL_ENABLE]) |->
        st.control[sacc_pkg::CTL_DONE_FLAG] && (st.result == $past(sarResult)))
        else $error("completion did not set flag and latch result");
    AST_MIN_CONVERT: assert property (@(posedge clk) disable iff (!rstn)
        finish |-> (st.busyCycles == sacc_pkg::CONVERT_SAR_CLOCKS - sacc_pkg::COUNT_ONE))
        else $error("conversion shorter than sixteen sar clocks");
    AST_TRACK_LEN: assert property (@(posedge clk) disable iff (!rstn || sfrWr)
        $rose(st.state == sacc_pkg::SACC_TRACK) && st.control[sacc_pkg::CTL_ENABLE]
        && (st.adcConfiguration[sacc_pkg::CFG_DIV_HI:sacc_pkg::CFG_DIV_LO] == '0)
        |-> trackThreeSeq)
        else $error("tracking did not last three sar clocks");
    AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!rstn)
        !st.control[sacc_pkg::CTL_ENABLE] |-> !converterPowerOn && !trackEnable ##1 !busy)
        else $error("converter active while disabled");
    AST_STANDBY: assert property (@(posedge clk) disable iff (!rstn)
        chipStandby |-> !trackEnable)
        else $error("tracking during standby");
    AST_CONT_TRACK: assert property (@(posedge clk) disable iff (!rstn)
        st.control[sacc_pkg::CTL_ENABLE] && !st.control[sacc_pkg::CTL_TRACK_MODE]
        && !chipStandby |-> trackEnable == !sampleConvert)
        else $error("continuous tracking broken");
    AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rstn)
        st.control[sacc_pkg::CTL_DONE_FLAG] && !ctlWrite |=> st.control[sacc_pkg::CTL_DONE_FLAG])
        else $error("complete flag cleared by hardware");
    AST_WINDOW: assert property (@(posedge clk) disable iff (!rstn)
        finish && st.control[sacc_pkg::CTL_ENABLE]
        && sacc_pkg::inWindow(sarResult, st.winLow, st.winHigh)
        |=> st.control[sacc_pkg::CTL_WIN_FLAG])
        else $error("window match did not set flag");
endmodule : sar_adc_conversion_control
`default_nettype wire

// ---- testbench/sacc_analog_model.sv ----
// behavioural analog channels behind the multiplexer and gain stage
`timescale 1ns/1ps
`default_nettype none
module sacc_analog_model
(
    // clock
    input wire logic clk,
    // front end control
    input wire logic converterPowerOn,
    input wire logic sampleConvert,
    input wire logic [2:0] gainSelect,
    input wire logic [1:0] portSelect,
    input wire logic [2:0] pinSelect,
    // converted value
    output logic [7:0] sarResult
);
    logic [7:0] noise = 8'h5a;

    // unpowered or idle array gives a pattern that changes every cycle
    always @(posedge clk)
    begin
        noise <= ~noise;
    end

    // each pin and gain gives its own code, only while powered and converting
    assign sarResult = (converterPowerOn && sampleConvert) ?
        {portSelect, pinSelect, gainSelect} : noise;
endmodule : sacc_analog_model
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the sar conversion control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic [7:0] sfrWrData = 8'h00;
    logic sfrWr = 1'b0;
    logic sfrRd = 1'b0;
    logic [7:0] sfrRdData;
    logic timer2Overflow = 1'b0;
    logic chipStandby = 1'b0;
    logic eocIrqEnable = 1'b0;
    logic eocIrq;
    logic [7:0] sarResult;
    logic converterPowerOn;
    logic trackEnable;
    logic sampleConvert;
    logic [2:0] gainSelect;
    logic [1:0] portSelect;
    logic [2:0] pinSelect;
    int errCount = 0;
    int checks = 0;

    always #50 clk = ~clk;

    sar_adc_conversion_control i_sar_adc_conversion_control
    (
        .clk(clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWr(sfrWr),
        .sfrRd(sfrRd), .sfrRdData(sfrRdData), .timer2Overflow(timer2Overflow),
        .chipStandby(chipStandby), .eocIrqEnable(eocIrqEnable), .eocIrq(eocIrq),
        .sarResult(sarResult), .converterPowerOn(converterPowerOn), .trackEnable(trackEnable),
        .sampleConvert(sampleConvert), .gainSelect(gainSelect), .portSelect(portSelect),
        .pinSelect(pinSelect)
    );

    sacc_analog_model i_sacc_analog_model
    (
        .clk(clk), .converterPowerOn(converterPowerOn), .sampleConvert(sampleConvert),
        .gainSelect(gainSelect), .portSelect(portSelect), .pinSelect(pinSelect),
        .sarResult(sarResult)
    );

    task automatic wrapUp();
        if (errCount == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrapUp

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            errCount++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chkCount(input int got, input int exp, input string what);
        checks++;
        if (got != exp)
        begin
            errCount++;
            $display("[ERR] %0t %s: got %0d expected %0d", $time, what, got, exp);
        end
    endtask : chkCount

    task automatic hang();
        errCount++;
        $display("[ERR] %0t wait bound used up", $time);
        wrapUp();
    endtask : hang

    task automatic tick();
        @(posedge clk);
        #10;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick();
        sfrAddr = a;
        sfrWrData = d;
        sfrWr = 1'b1;
        tick();
        sfrWr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        tick();
        sfrAddr = a;
        sfrRd = 1'b1;
        tick();
        sfrRd = 1'b0;
        d = sfrRdData;
    endtask : rd

    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp, what);
    endtask : rdChk

    task automatic pulseTimer();
        tick();
        timer2Overflow = 1'b1;
        tick();
        timer2Overflow = 1'b0;
    endtask : pulseTimer

    // counts tracking cycles, then conversion cycles, until conversion ends
    task automatic measure(output int trk, output int cnv);
        trk = 0;
        cnv = 0;
        for (int i = 0; i < 2000; i++)
        begin
            if (sampleConvert === 1'b1)
            begin
                cnv++;
                chk({7'h0, trackEnable}, 8'h00, "tracking during convert");
            end
            else if (cnv > 0)
                return;
            else if (trackEnable === 1'b1)
                trk++;
            tick();
        end
        hang();
    endtask : measure

    task automatic testReset();
        chk({5'h0, gainSelect}, 8'h01, "gain after reset");
        chk({7'h0, converterPowerOn}, 8'h00, "power after reset");
        chk({7'h0, trackEnable}, 8'h00, "tracking after reset");
        rdChk(sacc_pkg::ADDR_CONTROL, 8'h00, "control reset");
        rdChk(sacc_pkg::ADDR_CONFIG, 8'h01, "config reset");
        rdChk(sacc_pkg::ADDR_INPUT_SEL, sacc_pkg::RST_INPUT_SEL, "input select reset");
        rdChk(sacc_pkg::ADDR_WIN_HIGH, sacc_pkg::RST_WIN_HIGH, "window high reset");
        rdChk(sacc_pkg::ADDR_WIN_LOW, sacc_pkg::RST_WIN_LOW, "window low reset");
        rdChk(8'h10, 8'h00, "unmapped read");
        wr(sacc_pkg::ADDR_RESULT, 8'h55);
        rdChk(sacc_pkg::ADDR_RESULT, 8'h00, "result is read only");
    endtask : testReset

    task automatic testEnable();
        wr(sacc_pkg::ADDR_CONTROL, 8'h80);
        chk({7'h0, converterPowerOn}, 8'h01, "power when enabled");
        chk({7'h0, trackEnable}, 8'h01, "continuous tracking");
        chipStandby = 1'b1;
        tick();
        chk({7'h0, trackEnable}, 8'h00, "tracking in standby");
        chipStandby = 1'b0;
        tick();
        chk({7'h0, trackEnable}, 8'h01, "tracking after standby");
    endtask : testEnable

    task automatic testRefused();
        wr(sacc_pkg::ADDR_CONTROL, 8'h00);
        wr(sacc_pkg::ADDR_CONTROL, 8'h10);
        rdChk(sacc_pkg::ADDR_CONTROL, 8'h00, "start while disabled");
        for (int m = 1; m < 4; m++)
        begin
            wr(sacc_pkg::ADDR_CONTROL, 8'h80 | 8'(m << 2));
            wr(sacc_pkg::ADDR_CONTROL, 8'h90 | 8'(m << 2));
            rdChk(sacc_pkg::ADDR_CONTROL, 8'h80 | 8'(m << 2), "busy write off mode 00");
        end
        wr(sacc_pkg::ADDR_CONTROL, 8'h80);
        pulseTimer();
        chk({7'h0, sampleConvert}, 8'h00, "timer start in mode 00");
        rdChk(sacc_pkg::ADDR_CONTROL, 8'h80, "timer ignored in mode 00");
        wr(sacc_pkg::ADDR_CONTROL, 8'h00);
    endtask : testRefused

    task automatic testConvert(input logic [2:0] div, input logic tm, input logic [1:0] port,
                               input logic [2:0] pin, input logic [2:0] gain);
        int trk;
        int cnv;
        int i;
        int n;
        logic [7:0] d;
        logic [7:0] base;
        n = 1 << div;
        base = {1'b1, tm, 6'h00};
        eocIrqEnable = tm ^ div[0];
        wr(sacc_pkg::ADDR_CONFIG, {div, 2'h0, gain});
        wr(sacc_pkg::ADDR_INPUT_SEL, {3'h0, port, pin});
        wr(sacc_pkg::ADDR_CONTROL, base);
        wr(sacc_pkg::ADDR_CONTROL, base | 8'h10);
        measure(trk, cnv);
        chkCount(trk, tm ? 3 * n : 0, "tracking cycles");
        chkCount(cnv, 16 * n, "conversion cycles");
        chk({5'h0, gainSelect}, {5'h0, gain}, "gain field");
        chk({3'h0, portSelect, pinSelect}, {3'h0, port, pin}, "pin routing");
        for (i = 0; i < 20; i++)
        begin
            rd(sacc_pkg::ADDR_CONTROL, d);
            if (d[5] === 1'b1)
                break;
        end
        if (i == 20)
            hang();
        chk(d, base | 8'h20 | {6'h0, ~port[1], 1'b0}, "flags after done");
        chk({7'h0, eocIrq}, {7'h0, eocIrqEnable}, "done interrupt");
        rdChk(sacc_pkg::ADDR_RESULT, {port, pin, gain}, "latched result");
        wr(sacc_pkg::ADDR_CONTROL, base | 8'h22);
        rdChk(sacc_pkg::ADDR_CONTROL, base | 8'h20 | {6'h0, ~port[1], 1'b0}, "flag kept");
        wr(sacc_pkg::ADDR_CONTROL, base);
        rdChk(sacc_pkg::ADDR_CONTROL, base, "flags cleared");
        chk({7'h0, eocIrq}, 8'h00, "interrupt cleared");
    endtask : testConvert

    task automatic testTimer(input logic tm);
        int trk;
        int cnv;
        logic [7:0] base;
        base = {1'b1, tm, 4'h3, 2'h0};
        wr(sacc_pkg::ADDR_CONFIG, 8'h01);
        wr(sacc_pkg::ADDR_INPUT_SEL, 8'h00);
        wr(sacc_pkg::ADDR_CONTROL, base);
        pulseTimer();
        measure(trk, cnv);
        chkCount(trk, tm ? 3 : 0, "timer tracking cycles");
        chkCount(cnv, 16, "timer conversion cycles");
        rdChk(sacc_pkg::ADDR_CONTROL, base | 8'h22, "timer done flags");
        rdChk(sacc_pkg::ADDR_RESULT, 8'h01, "timer result");
        wr(sacc_pkg::ADDR_CONTROL, base);
        pulseTimer();
        rdChk(sacc_pkg::ADDR_CONTROL, base | 8'h10, "busy during conversion");
        measure(trk, cnv);
        wr(sacc_pkg::ADDR_CONTROL, 8'h00);
    endtask : testTimer

    initial
    begin
        repeat (16) @(posedge clk);
        #10;
        rstn = 1'b1;
        testReset();
        testEnable();
        testRefused();
        wr(sacc_pkg::ADDR_WIN_HIGH, 8'h7f);
        for (int d = 0; d < 5; d++)
            for (int t = 0; t < 2; t++)
                testConvert(3'(d), 1'(t), 2'(d + t), 3'(d + 2), 3'(d));
        testTimer(1'b0);
        testTimer(1'b1);
        wrapUp();
    end
endmodule : testbench
`default_nettype wire
